// *** bdm_pkg.sv ***
// Purpose: constants and carriers for the banked data memory block
// Assumes: 12-bit data space, 21-bit program counter, 16-bit instruction words
// Notes:   all addresses are byte addresses of the data space, except the program memory address of a table transfer
package bdm_pkg;
  localparam int DATA_AW       = 12;                 // data address width
  localparam int DATA_BYTES    = 4096;               // full data space
  localparam int BANK_BYTES    = 256;                // bytes per bank
  localparam int BANK_W        = 4;                  // stored bank number width
  localparam int PC_W          = 21;                 // program counter width
  localparam int TP_W          = 22;                 // table pointer width
  localparam logic [3:0]  TRAIL_TAG      = 4'hf;     // top nibble of a trailing word
  localparam logic [11:0] SFR_BASE       = 12'hf60;  // lowest special register
  localparam logic [11:0] RAM_TOP_SMALL  = 12'h7ff;  // last general byte, small variant
  localparam logic [11:0] RAM_TOP_LARGE  = 12'heff;  // last general byte, large variants
  localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;    // first 96 bytes low, rest high
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hf;     // bank of access-high half
  // special register addresses handled inside this block
  localparam logic [11:0] A_PC_UPPER_LATCH  = 12'hffb;
  localparam logic [11:0] A_PC_HIGH_LATCH  = 12'hffa;
  localparam logic [11:0] A_PCL     = 12'hff9;
  localparam logic [11:0] A_TBLPTRU = 12'hff8;
  localparam logic [11:0] A_TBLPTRH = 12'hff7;
  localparam logic [11:0] A_TBLPTRL = 12'hff6;
  localparam logic [11:0] A_TABLE_LATCH  = 12'hff5;
  localparam logic [11:0] A_WORKING_REGISTER    = 12'hfe8;
  localparam logic [11:0] A_BSR     = 12'hfe0;
  localparam logic [11:0] A_IND0    = 12'hfef;
  localparam logic [11:0] A_IND1    = 12'hfe7;
  localparam logic [11:0] A_IND2    = 12'hfdf;
  localparam logic [11:0] A_FSR0H   = 12'hfea;
  localparam logic [11:0] A_FSR0L   = 12'hfe9;
  localparam logic [11:0] A_FSR1H   = 12'hfe2;
  localparam logic [11:0] A_FSR1L   = 12'hfe1;
  localparam logic [11:0] A_FSR2H   = 12'hfda;
  localparam logic [11:0] A_FSR2L   = 12'hfd9;
  // instruction opcode fields (upper bits of the leading word)
  localparam logic [3:0]  OP_MOVE   = 4'hc;          // reg_to_reg_move leading word
  localparam logic [9:0]  OP_LDPTR  = 10'h3b8;       // load_pointer_literal, 1110 1110 00
  localparam logic [5:0]  OP_ADD_WORKING_TO_FILE  = 6'h09;         // add_working_to_file, 0010 01
  localparam logic [5:0]  OP_TSTZ   = 6'h19;         // test_skip_if_zero, 0110 011
  // table transfer commands
  typedef enum logic [1:0] {BDM_TB_NONE, BDM_TB_READ, BDM_TB_WRITE} bdm_tbl_e;
  // one executed instruction slot from the pipeline
  typedef struct packed {
    logic        valid;   // slot holds an instruction this cycle
    logic [15:0] word;    // the instruction word
  } bdm_instr_s;
  // one byte exchanged with program memory
  typedef struct packed {
    logic              req;    // one-cycle request
    logic              wr;     // 1 = latch to memory
    logic [TP_W-1:0]   addr;   // program memory byte address
    logic [7:0]        data;   // byte written
  } bdm_tbl_s;
endpackage

// *** bdm_core.sv ***
// Purpose: banked data memory, pointer and two-word decode for a small core
// Assumes: one instruction slot per clock; program memory answers table reads in one cycle
// Notes:   general RAM has no reset; only control registers are cleared
// Summary of operation
// - top nibble all ones marks trailing word
// - trailing word low twelve bits give operand
// - leading word fetches and uses trailing operand
// - lone trailing word executes as no-operation
// - add working into pc low jumps
// - table pointer bytes, one byte per transfer
// - every data address is twelve bits
// - sixteen banks, bank select low nibble
// - bank select upper nibble unimplemented
// - special registers F60h to FFFh
// - unimplemented locations read as zero
// - general RAM size per variant
// - indirect pointers hold full twelve-bit address
// - register move two words, two cycles
// - access bit zero uses access bank
// - access bit one uses bank select
// - general registers keep value through reset
// - pc low write loads, read by add copies latches
// - pc steps by two, bit zero zero
`timescale 1ns/1ns
module bdm_core #(
  parameter bit LARGE = 1'b1                         // 1 = fifteen general banks
) (
  input  wire logic               i_clk,
  input  wire logic               i_sys_rst,
  input  wire bdm_pkg::bdm_instr_s i_instr,          // executed instruction slot
  input  wire logic [7:0]         i_tbl_rdata,       // byte returned by program memory
  output logic [bdm_pkg::PC_W-1:0] o_pc,             // program counter
  output logic [7:0]              o_working_register,            // working register
  output logic [7:0]              o_bank_select,     // bank select as read
  output logic                    o_skip,            // next slot will be skipped
  output logic                    o_busy,            // second cycle of a two-word op
  output bdm_pkg::bdm_tbl_s       o_tbl              // table transfer request
);
  // general RAM, no reset on purpose
  logic [7:0] ram [bdm_pkg::DATA_BYTES];
  logic [3:0]  bank_select;                          // only low nibble stored
  logic [11:0] fsr [3];                               // indirect pointers
  logic [bdm_pkg::PC_W-1:0] pc;
  logic [7:0]  pc_high_latch;
  logic [4:0]  pc_upper_latch;
  logic [bdm_pkg::TP_W-1:0] table_pointer;
  logic [7:0]  table_latch;
  logic [7:0]  working_register;
  logic        skip;                                 // drop next word
  logic        pend;                                 // leading word waits for trailer
  logic [15:0] lead;                                 // held leading word
  logic        tbl_rd_pend;                          // table read in flight
  // next values
  logic [bdm_pkg::PC_W-1:0] next_pc;
  logic [7:0]  next_pc_high_latch;
  logic [4:0]  next_pc_upper_latch;
  logic [bdm_pkg::TP_W-1:0] next_table_pointer;
  logic [7:0]  next_table_latch;
  logic [7:0]  next_working_register;
  logic [3:0]  next_bank_select;
  logic [11:0] next_fsr [3];
  logic        next_skip;
  logic        next_pend;
  logic [15:0] next_lead;
  logic        next_tbl_rd_pend;
  bdm_pkg::bdm_tbl_s next_tbl;
  logic        wr_en;                                // data write this cycle
  logic [11:0] wr_addr;
  logic [7:0]  wr_data;
  logic [11:0] rd_addr;
  logic [7:0]  rd_data;

  // trailing-word test, used by decode and skip logic
  function automatic logic is_trail(input logic [15:0] w);
    is_trail = (w[15:12] == bdm_pkg::TRAIL_TAG);
  endfunction

  // direct address from an 8-bit field and the access bit
  function automatic logic [11:0] dir_addr(input logic [7:0] f, input logic a, input logic [3:0] b);
    if (!a) begin
      // access bank: low 96 bytes of bank 0, top 160 of bank 15
      dir_addr = (f < bdm_pkg::ACCESS_SPLIT) ? {4'h0, f} : {bdm_pkg::ACCESS_HI_BANK, f};
    end else begin
      dir_addr = {b, f};
    end
  endfunction

  // map an indirect operand address onto its pointer
  function automatic logic [11:0] resolve(input logic [11:0] a, input logic [11:0] p0,
                                          input logic [11:0] p1, input logic [11:0] p2);
    case (a)
      bdm_pkg::A_IND0: resolve = p0;
      bdm_pkg::A_IND1: resolve = p1;
      bdm_pkg::A_IND2: resolve = p2;
      default:         resolve = a;
    endcase
  endfunction

  // general RAM is present only below the variant's top
  function automatic logic is_ram(input logic [11:0] a);
    is_ram = LARGE ? (a <= bdm_pkg::RAM_TOP_LARGE) : (a <= bdm_pkg::RAM_TOP_SMALL);
  endfunction

  // read mux: RAM, core special registers, zero elsewhere
  always_comb begin
    rd_data = 8'h00;
    if (is_ram(rd_addr)) begin
      rd_data = ram[rd_addr];
    end else begin
      case (rd_addr)
        bdm_pkg::A_PC_UPPER_LATCH:  rd_data = {3'h0, pc_upper_latch};
        bdm_pkg::A_PC_HIGH_LATCH:  rd_data = pc_high_latch;
        bdm_pkg::A_PCL:     rd_data = pc[7:0];
        bdm_pkg::A_TBLPTRU: rd_data = {2'h0, table_pointer[21:16]};
        bdm_pkg::A_TBLPTRH: rd_data = table_pointer[15:8];
        bdm_pkg::A_TBLPTRL: rd_data = table_pointer[7:0];
        bdm_pkg::A_TABLE_LATCH:  rd_data = table_latch;
        bdm_pkg::A_WORKING_REGISTER:    rd_data = working_register;
        bdm_pkg::A_BSR:     rd_data = {4'h0, bank_select};
        bdm_pkg::A_FSR0H:   rd_data = {4'h0, fsr[0][11:8]};
        bdm_pkg::A_FSR0L:   rd_data = fsr[0][7:0];
        bdm_pkg::A_FSR1H:   rd_data = {4'h0, fsr[1][11:8]};
        bdm_pkg::A_FSR1L:   rd_data = fsr[1][7:0];
        bdm_pkg::A_FSR2H:   rd_data = {4'h0, fsr[2][11:8]};
        bdm_pkg::A_FSR2L:   rd_data = fsr[2][7:0];
        default:            rd_data = 8'h00;
      endcase
    end
  end

  // decode and execute: next values for all control state
  always_comb begin
    logic [15:0] w;
    logic [11:0] src;
    logic [8:0]  sum;
    w = i_instr.word;
    src = 12'h000;
    sum = 9'h000;
    next_pc = pc;
    next_pc_high_latch = pc_high_latch;
    next_pc_upper_latch = pc_upper_latch;
    next_table_pointer = table_pointer;
    next_table_latch = tbl_rd_pend ? i_tbl_rdata : table_latch;
    next_working_register = working_register;
    next_bank_select = bank_select;
    for (int k = 0; k < 3; k++) begin
      next_fsr[k] = fsr[k];
    end
    next_skip = skip;
    next_pend = pend;
    next_lead = lead;
    next_tbl_rd_pend = 1'b0;
    next_tbl = '0;
    wr_en = 1'b0;
    wr_addr = 12'h000;
    wr_data = 8'h00;
    rd_addr = resolve(dir_addr(w[7:0], w[8], bank_select), fsr[0], fsr[1], fsr[2]);
    if (i_instr.valid) begin
      next_pc = pc + 21'h000002;
      if (pend) begin
        // second cycle: use the trailing operand
        next_pend = 1'b0;
        if (lead[15:12] == bdm_pkg::OP_MOVE) begin
          src = resolve(lead[11:0], fsr[0], fsr[1], fsr[2]);
          rd_addr = src;
          wr_en = 1'b1;
          wr_addr = resolve(w[11:0], fsr[0], fsr[1], fsr[2]);
          wr_data = rd_data;
        end else begin
          // load_pointer_literal: full twelve-bit address
          next_fsr[lead[5:4] == 2'h3 ? 2'h2 : lead[5:4]] = {lead[3:0], w[7:0]};
        end
      end else if (skip) begin
        next_skip = 1'b0;                            // skipped word, one cycle
        next_skip = 1'b0;
        if (is_trail(w)) begin
          next_skip = 1'b0;                          // lone trailer is a no-op
        end
      end else if (is_trail(w)) begin
        next_skip = 1'b0;                            // no side effects
      end else if (w[15:12] == bdm_pkg::OP_MOVE || w[15:6] == bdm_pkg::OP_LDPTR) begin
        next_pend = 1'b1;                            // two-word start
        next_lead = w;
      end else if (w[15:9] == {bdm_pkg::OP_TSTZ, 1'b1}) begin
        // the encoding is 0110 011a; a zero byte drops the following slot
        next_skip = (rd_data == 8'h00);              // test_skip_if_zero
      end else if (w[15:10] == bdm_pkg::OP_ADD_WORKING_TO_FILE) begin
        sum = {1'b0, rd_data} + {1'b0, working_register};
        if (rd_addr == bdm_pkg::A_PCL) begin
          // reading pc low refreshes both latches, whatever the destination
          next_pc_high_latch = pc[15:8];
          next_pc_upper_latch = pc[20:16];
        end
        if (w[9]) begin
          // a write back into pc low is the computed jump
          wr_en = 1'b1;
          wr_addr = rd_addr;
          wr_data = sum[7:0];
        end else begin
          next_working_register = sum[7:0];
        end
      end else if (w[15:12] == 4'h6 && w[11:9] == 3'h7) begin
        // move working register to file
        wr_en = 1'b1;
        wr_addr = rd_addr;
        wr_data = working_register;
      end else if (w[15:8] == 8'h0e) begin
        next_working_register = w[7:0];              // move literal to working
      end else if (w[15:4] == 12'h010) begin
        next_bank_select = w[3:0];
      end else if (w[15:2] == 14'h0002) begin
        // table read/write, one byte each
        next_tbl.req = 1'b1;
        next_tbl.wr = w[1];
        next_tbl.addr = table_pointer;
        next_tbl.data = table_latch;
        next_tbl_rd_pend = !w[1];
        if (w[0]) begin
          next_table_pointer = table_pointer + 22'h000001;
        end
      end
    end
    // register writes that land on core special registers
    if (wr_en) begin
      case (wr_addr)
        bdm_pkg::A_PCL: begin
          // latches as refreshed by a read of pc low in this same slot
          next_pc = {next_pc_upper_latch, next_pc_high_latch, wr_data[7:1], 1'b0};
        end
        bdm_pkg::A_PC_UPPER_LATCH:  next_pc_upper_latch = wr_data[4:0];
        bdm_pkg::A_PC_HIGH_LATCH:  next_pc_high_latch = wr_data;
        bdm_pkg::A_TBLPTRU: next_table_pointer[21:16] = wr_data[5:0];
        bdm_pkg::A_TBLPTRH: next_table_pointer[15:8] = wr_data;
        bdm_pkg::A_TBLPTRL: next_table_pointer[7:0] = wr_data;
        bdm_pkg::A_TABLE_LATCH:  next_table_latch = wr_data;
        bdm_pkg::A_WORKING_REGISTER:    next_working_register = wr_data;
        bdm_pkg::A_BSR:     next_bank_select = wr_data[3:0];
        bdm_pkg::A_FSR0H:   next_fsr[0][11:8] = wr_data[3:0];
        bdm_pkg::A_FSR0L:   next_fsr[0][7:0] = wr_data;
        bdm_pkg::A_FSR1H:   next_fsr[1][11:8] = wr_data[3:0];
        bdm_pkg::A_FSR1L:   next_fsr[1][7:0] = wr_data;
        bdm_pkg::A_FSR2H:   next_fsr[2][11:8] = wr_data[3:0];
        bdm_pkg::A_FSR2L:   next_fsr[2][7:0] = wr_data;
        default: ;
      endcase
    end
  end

  // control registers, cleared by reset
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pc <= '0;
      pc_high_latch <= 8'h00;
      pc_upper_latch <= 5'h00;
      table_pointer <= '0;
      table_latch <= 8'h00;
      working_register <= 8'h00;
      bank_select <= 4'h0;
      for (int k = 0; k < 3; k++) begin
        fsr[k] <= 12'h000;
      end
      skip <= 1'b0;
      // a reset never leaves half a two-word op pending
      pend <= 1'b0;
      lead <= 16'h0000;
      tbl_rd_pend <= 1'b0;
      o_tbl <= '0;
    end else begin
      pc <= next_pc;
      pc_high_latch <= next_pc_high_latch;
      pc_upper_latch <= next_pc_upper_latch;
      table_pointer <= next_table_pointer;
      table_latch <= next_table_latch;
      working_register <= next_working_register;
      bank_select <= next_bank_select;
      for (int k = 0; k < 3; k++) begin
        fsr[k] <= next_fsr[k];
      end
      skip <= next_skip;
      pend <= next_pend;
      lead <= next_lead;
      tbl_rd_pend <= next_tbl_rd_pend;
      o_tbl <= next_tbl;
    end
  end

  // general RAM writes ignore reset so contents survive it
  // no reset branch here on purpose: clearing would cost a 4096-step sweep
  always_ff @(posedge i_clk) begin
    if (wr_en && is_ram(wr_addr)) begin
      ram[wr_addr] <= wr_data;
    end
  end

  // outputs mirror flip-flops
  assign o_pc = pc;
  assign o_working_register = working_register;
  assign o_bank_select = {4'h0, bank_select};
  assign o_skip = skip;
  assign o_busy = pend;
endmodule

// *** bdm_prog_mem.sv ***
// Purpose: program memory stand-in answering table transfers of the core
// Assumes: a read byte is wanted in the request cycle or the one after it
// Notes:   outside that span the data lines show the inverse of the last byte
`timescale 1ns/1ns
module bdm_prog_mem (
  input  wire logic              i_clk,
  input  wire bdm_pkg::bdm_tbl_s i_tbl,
  output logic [7:0]             o_rdata
);
  logic [21:0] held_addr = '0;   // address of the last request
  logic        hold      = 1'b0; // byte still held one more cycle
  // remember the request so the byte survives one extra cycle
  always_ff @(posedge i_clk) begin
    hold <= i_tbl.req && !i_tbl.wr;
    if (i_tbl.req) begin
      held_addr <= i_tbl.addr;
    end
  end
  // one byte per transfer, derived from the byte address; released lines never repeat the byte
  always_comb begin
    if (i_tbl.req && !i_tbl.wr) begin
      o_rdata = i_tbl.addr[7:0] ^ 8'h5a;
    end else if (hold) begin
      o_rdata = held_addr[7:0] ^ 8'h5a;
    end else begin
      o_rdata = ~(held_addr[7:0] ^ 8'h5a);
    end
  end
endmodule

// *** bdm_core_sva.sv ***
// Purpose: port-level checks of banking, two-word decode and program counter
// Assumes: single clock domain, synchronous active-high reset
// Notes:   lone trailers and skipped leads must only advance the counter
`timescale 1ns/1ns
module bdm_core_sva (
  input wire logic                    i_clk,
  input wire logic                    i_sys_rst,
  input wire bdm_pkg::bdm_instr_s     i_instr,
  input wire logic [bdm_pkg::PC_W-1:0] o_pc,
  input wire logic [7:0]              o_working_register,
  input wire logic [7:0]              o_bank_select,
  input wire logic                    o_skip,
  input wire logic                    o_busy,
  input wire bdm_pkg::bdm_tbl_s       o_tbl
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic trail; // word carries the trailing tag
  logic lead2; // leading word of a two-word op
  assign trail = i_instr.word[15:12] == bdm_pkg::TRAIL_TAG;
  assign lead2 = i_instr.word[15:12] == bdm_pkg::OP_MOVE || i_instr.word[15:6] == bdm_pkg::OP_LDPTR;
  property p_pc_even;
    o_pc[0] == 1'b0;
  endproperty
  a_pc_even: assert property (p_pc_even) else $error("pc bit zero set");
  property p_bank_upper;
    o_bank_select[7:4] == 4'h0;
  endproperty
  a_bank_upper: assert property (p_bank_upper) else $error("bank upper nibble set");
  property p_trail_step;
    i_instr.valid && trail && !o_busy |=> o_pc == $past(o_pc) + 21'd2 && $stable(o_working_register) && $stable(o_bank_select);
  endproperty
  a_trail_step: assert property (p_trail_step) else $error("lone trailer had an effect");
  property p_lead_hold;
    i_instr.valid && !o_skip && !o_busy && lead2 |=> o_busy && o_pc == $past(o_pc) + 21'd2;
  endproperty
  a_lead_hold: assert property (p_lead_hold) else $error("lead word not held");
  property p_busy_once;
    o_busy && i_instr.valid |=> !o_busy;
  endproperty
  a_busy_once: assert property (p_busy_once) else $error("two-word op longer than two slots");
  property p_skip_lead;
    o_skip && i_instr.valid && lead2 |=> !o_busy && o_pc == $past(o_pc) + 21'd2;
  endproperty
  a_skip_lead: assert property (p_skip_lead) else $error("skipped lead cost more than a slot");
  property p_idle_stands;
    !i_instr.valid |=> $stable(o_pc) && $stable(o_working_register) && !o_tbl.req;
  endproperty
  a_idle_stands: assert property (p_idle_stands) else $error("state moved without a slot");
  property p_bsr_literal;
    i_instr.valid && !o_skip && !o_busy && i_instr.word[15:4] == 12'h010
      |=> o_bank_select == {4'h0, $past(i_instr.word[3:0])};
  endproperty
  a_bsr_literal: assert property (p_bsr_literal) else $error("bank load wrong");
  c_move: cover property (o_busy ##1 !o_busy);
  c_skip: cover property (o_skip && i_instr.valid && lead2);
  c_tbl: cover property (o_tbl.req);
endmodule

// *** bdm_core_tb_top.sv ***
// Purpose: directed scenarios for banking, two-word ops, pc latches and table reads
// Assumes: simplified encodings 0e literal, 010k bank, 6e/6f store, 0008 table read
// Notes:   reads go through add into a cleared working register
`timescale 1ns/1ns
module bdm_core_tb_top;
  logic                i_clk = 1'b0, i_sys_rst = 1'b1;
  bdm_pkg::bdm_instr_s i_instr = '0;
  logic [7:0]          i_tbl_rdata, o_working_register, o_bank_select;
  logic [20:0]         o_pc;
  logic                o_skip, o_busy;
  bdm_pkg::bdm_tbl_s   o_tbl;
  int                  fail_count = 0, total_checks = 0;
  bdm_core #(.LARGE(1'b1)) i_bdm_core (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_instr(i_instr),
    .i_tbl_rdata(i_tbl_rdata), .o_pc(o_pc), .o_working_register(o_working_register), .o_bank_select(o_bank_select),
    .o_skip(o_skip), .o_busy(o_busy), .o_tbl(o_tbl));
  bdm_prog_mem i_bdm_prog_mem (.i_clk(i_clk), .i_tbl(o_tbl), .o_rdata(i_tbl_rdata));
  initial forever #5 i_clk = ~i_clk;
  // one slot per call; valid stays up so back-to-back slots never toggle it
  task automatic exec(input logic [15:0] w);
    i_instr = '{1'b1, w};
    @(posedge i_clk);
    #1;
  endtask
  task automatic idle;
    i_instr.valid = 1'b0;
    @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input logic [21:0] got, input logic [21:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic a, input logic [7:0] f, input logic [7:0] v);
    exec({8'h0e, v});
    exec({7'b0110111, a, f});
  endtask
  // clearing the working register first turns the add into a plain read
  task automatic rd(input logic a, input logic [7:0] f);
    exec(16'h0e00);
    exec({7'b0010010, a, f});
  endtask
  task automatic bank(input logic [3:0] k);
    exec({12'h010, k});
  endtask
  task automatic t_reset;
    chk(o_pc, 0, "pc after reset");
    chk({o_working_register, o_bank_select}, 0, "registers after reset");
    chk({o_busy, o_skip, o_tbl.req}, 0, "flags after reset");
    $display("test reset done");
  endtask
  task automatic t_banks;
    bank(4'h0); wr(1, 8'h10, 8'ha5); bank(4'h3); wr(1, 8'h10, 8'h5a);
    wr(0, 8'he0, 8'hff);
    chk(o_bank_select, 8'h0f, "bank upper nibble");
    bank(4'he); wr(1, 8'hff, 8'h3c);
    bank(4'h3); rd(1, 8'h10); chk(o_working_register, 8'h5a, "bank 3 byte");
    rd(0, 8'h10); chk(o_working_register, 8'ha5, "access low ignores bank");
    bank(4'he); rd(1, 8'hff); chk(o_working_register, 8'h3c, "last general byte");
    exec(16'h0e11); exec(16'h2460); chk(o_working_register, 8'h11, "unused special reads zero");
    bank(4'hf); exec(16'h2500); chk(o_working_register, 8'h11, "unused bank 15 reads zero");
    $display("test banks done");
  endtask
  task automatic t_move;
    logic [20:0] p;
    bank(4'h1); wr(1, 8'h23, 8'h77); bank(4'h4); wr(1, 8'h56, 8'h00);
    p = o_pc; exec(16'hc123);
    chk(o_busy, 1, "lead held");
    exec(16'hf456);
    chk(o_busy, 0, "trailer done");
    chk(o_pc, p + 21'd4, "two slots two steps");
    rd(1, 8'h56); chk(o_working_register, 8'h77, "moved byte");
    $display("test move done");
  endtask
  task automatic t_skip;
    logic [20:0] p;
    bank(4'h4); wr(1, 8'h56, 8'h99); bank(4'h0); wr(1, 8'h20, 8'h00); wr(1, 8'h21, 8'h01);
    exec(16'h6721); chk(o_skip, 0, "nonzero keeps slot");
    exec(16'h6720); chk(o_skip, 1, "zero drops slot");
    p = o_pc; exec(16'hc123);
    chk(o_busy, 0, "skipped lead not held");
    chk(o_pc, p + 21'd2, "skipped lead one step");
    exec(16'hf456);
    chk({o_busy, o_skip}, 0, "lone trailer idle");
    chk(o_pc, p + 21'd4, "lone trailer step");
    bank(4'h4); rd(1, 8'h56); chk(o_working_register, 8'h99, "destination untouched");
    $display("test skip done");
  endtask
  task automatic t_ptr;
    exec(16'hee13); exec(16'hf045); wr(0, 8'he7, 8'h3c);
    rd(0, 8'he2); chk(o_working_register, 8'h03, "pointer high");
    rd(0, 8'he1); chk(o_working_register, 8'h45, "pointer low");
    bank(4'h3); rd(1, 8'h45); chk(o_working_register, 8'h3c, "indirect write");
    $display("test pointer done");
  endtask
  task automatic t_pc;
    logic [20:0] p;
    wr(0, 8'hfa, 8'h12); wr(0, 8'hfb, 8'h03); wr(0, 8'hf9, 8'h40);
    chk(o_pc, 21'h031240, "pc low write loads latches");
    wr(0, 8'hfa, 8'h00); p = o_pc; rd(0, 8'hf9);
    chk(o_pc, p + 21'd4, "pc low read does not jump");
    chk(o_working_register, 8'(p + 21'd2), "pc low read value");
    rd(0, 8'hfa);
    chk(o_working_register, 8'h12, "pc low read refills latch");
    exec(16'h0e07); p = o_pc; exec(16'h26f9);
    chk(o_pc, {p[20:8], (p[7:0] + 8'h07) & 8'hfe}, "computed jump");
    $display("test pc done");
  endtask
  task automatic t_table;
    wr(0, 8'hf6, 8'h34); wr(0, 8'hf7, 8'h12); wr(0, 8'hf8, 8'h21);
    exec(16'h0008);
    chk({o_tbl.req, o_tbl.wr}, 2'b10, "table read request");
    chk(o_tbl.addr, 22'h211234, "table byte address");
    idle;
    chk(o_tbl.req, 0, "request one cycle");
    rd(0, 8'hf5); chk(o_working_register, 8'h34 ^ 8'h5a, "table latch byte");
    exec(16'h000b);
    chk({o_tbl.req, o_tbl.wr}, 2'b11, "table write request");
    chk(o_tbl.data, 8'h34 ^ 8'h5a, "table write byte");
    chk(o_tbl.addr, 22'h211234, "table write address");
    rd(0, 8'hf6); chk(o_working_register, 8'h35, "table pointer stepped one byte");
    $display("test table done");
  endtask
  task automatic t_keep;
    idle; i_sys_rst = 1'b1;
    repeat (2) @(posedge i_clk);
    #1 i_sys_rst = 1'b0;
    chk(o_pc, 0, "pc after second reset");
    bank(4'h3); rd(1, 8'h10); chk(o_working_register, 8'h5a, "general byte kept");
    $display("test keep done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // about 100 slots are needed; the limit of 2000 cycles leaves wide room
  initial begin
    #20000;
    fail_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    report_and_stop;
  end
  initial begin
    repeat (4) @(posedge i_clk);
    #1 i_sys_rst = 1'b0;
    t_reset; t_banks; t_move; t_skip; t_ptr; t_pc; t_table; t_keep;
    report_and_stop;
  end
endmodule
bind bdm_core bdm_core_sva i_bdm_core_sva (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_instr(i_instr), .o_pc(o_pc),
  .o_working_register(o_working_register), .o_bank_select(o_bank_select), .o_skip(o_skip), .o_busy(o_busy), .o_tbl(o_tbl));
